// ### bench/host_model.sv
`timescale 1ns/10ps
module host_model #(
   parameter int BIT_CYC = 16
)(
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic act_i,
   output logic rxd_o,
   output logic cts_n_o
);
   initial
   begin
      rxd_o = 1'b1;
      cts_n_o = 1'b0;
   end
   // Stop bit cut to half a bit time plus one cycle so a reply start bit is not missed
   task automatic send(input logic [7:0] b, input logic need_act);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      while (need_act && act_i !== 1'b1) @(posedge clk_i);
      for (int i = 0; i < 10; i++)
      begin
         rxd_o <= f[i];
         repeat ((i == 9) ? BIT_CYC / 2 + 1 : BIT_CYC) @(posedge clk_i);
      end
   endtask : send
   task automatic recv(output logic [7:0] b);
      int n;
      n = 0;
      b = 8'hxx;
      while (txd_i !== 1'b0 && n < 4000)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n < 4000)
      begin
         repeat (BIT_CYC / 2) @(negedge clk_i);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CYC) @(negedge clk_i);
            b[i] = txd_i;
         end
         repeat (BIT_CYC) @(negedge clk_i);
      end
      @(posedge clk_i);
   endtask : recv
endmodule : host_model

// ### bench/radio_module_host_control_test.sv
`timescale 1ns/10ps
module radio_module_host_control_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o, q;
   logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
   logic rxd, txd, cts_n, rts_n, act, link, wake, mode;
   logic init = 1'b1, param = 1'b1, disc = 1'b1, role = 1'b0;
   logic [3:0] sel = 4'hf;
   logic [7:0] b;
   int n_mismatch = 0, comparisons = 0;
   always #4 clk_i = ~clk_i;
   radio_host_ctrl #(.MS_CYC(10), .SEARCH_MS(20), .RESUME_MS(5), .BIT_CYC(16)) DUT (
      .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .uart_rxd_i(rxd), .uart_txd_o(txd), .uart_cts_n_i(cts_n), .uart_rts_n_o(rts_n),
      .init_sleep_req_in(init), .param_change_req_in(param),
      .disconnect_resume_in(disc), .role_select_in(role), .active_sleep_ind_out(act),
      .link_state_ind_out(link), .host_wake_req_out(wake), .mode_ind_out(mode));
   host_model #(.BIT_CYC(16)) host (
      .clk_i(clk_i), .txd_i(txd), .act_i(act), .rxd_o(rxd), .cts_n_o(cts_n));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", s, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic finish_test;
      $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_connect;
      wb(1'b1, 8'h00, 32'h0000_0004);
      wb(1'b1, 8'h00, 32'h0000_0001);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("state", q[2:0], 32'h0000_0002);
      chk("link", link, 32'h0000_0001);
      chk("mode", mode, 32'h0000_0001);
   endtask : t_connect
   task automatic t_wake;
      role <= 1'b1;
      wb(1'b1, 8'h08, 32'h0000_005a);
      repeat (4) @(posedge clk_i);
      chk("wake", wake, 32'h0000_0001);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("held", q[15:8], 32'h0000_0001);
      role <= 1'b0;
      host.recv(b);
      chk("byte", b, 32'h0000_005a);
      chk("wake_off", wake, 32'h0000_0000);
      host.send(8'ha5, 1'b1);
      repeat (2) @(posedge clk_i);
      wb(1'b0, 8'h0c, 32'h0000_0000);
      chk("rx_byte", q, 32'h0000_01a5);
   endtask : t_wake
   task automatic t_disconnect;
      wb(1'b1, 8'h00, 32'h0000_0002);
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("state", q[2:0], 32'h0000_0003);
      chk("link", link, 32'h0000_0000);
      chk("mode", mode, 32'h0000_0000);
      disc <= 1'b0;
      repeat (80) @(posedge clk_i);
      disc <= 1'b1;
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk("resume", q[3:0], 32'h0000_0009);
   endtask : t_disconnect
   task automatic t_test_pins;
      wb(1'b1, 8'h00, 32'h0000_0008);
      @(posedge clk_i);
      chk("rts", rts_n, 32'h0000_0000);
      for (int k = 0; k < 5; k++)
      begin
         host.send((k < 4) ? 8'h32 + 8'(k) : 8'h33, 1'b0);
         host.send((k < 4) ? 8'h31 : 8'h30, 1'b0);
         host.recv(b);
         chk("resp0", b, 32'h0000_0000);
         host.recv(b);
         chk("resp1", b, 32'h0000_0000);
         chk("pin", ({mode, wake, link, act} >> ((k < 4) ? k : 1)) & 32'h0000_0001,
             32'(k < 4));
      end
   endtask : t_test_pins
   task automatic t_test_status;
      param <= 1'b0;
      role <= 1'b1;
      host.send(8'h39, 1'b0);
      host.send(8'h39, 1'b0);
      host.recv(b);
      chk("pins", b, 32'h0000_000d);
      host.recv(b);
      chk("st1", b, 32'h0000_0000);
      host.recv(b);
      chk("st2", b, 32'h0000_0000);
   endtask : t_test_status
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b0, 8'h10, 32'h0000_0000);
      chk("user", q, 32'h0000_0003);
      sel <= 4'he;
      wb(1'b1, 8'h10, 32'h0000_0000);
      sel <= 4'hf;
      wb(1'b0, 8'h10, 32'h0000_0000);
      chk("sel_off", q, 32'h0000_0003);
      chk("link0", link, 32'h0000_0000);
      t_connect();
      t_wake();
      t_disconnect();
      t_test_pins();
      t_test_status();
      finish_test();
   end
   initial
   begin
      #400000;
      n_mismatch++;
      finish_test();
   end
endmodule : radio_module_host_control_test

// ### core/radio_ctrl_consts.svh
`ifndef RADIO_CTRL_CONSTS_SVH
`define RADIO_CTRL_CONSTS_SVH
// Timing
`define CLK_HZ 125000000
`define BAUD_BPS 38400
`define BIT_CYC (`CLK_HZ / `BAUD_BPS)
`define MS_PER_S 1000
`define MS_CYC (`CLK_HZ / `MS_PER_S)
`define SEARCH_S 60
`define SEARCH_MS (`SEARCH_S * `MS_PER_S)
`define RESUME_MS 300
// Sizes
`define WAKE_DEPTH 128
`define PKT_MAX 20
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RADIO_TX 8'h08
`define REG_RADIO_RX 8'h0C
`define REG_USER 8'h10
// Control bits (write one to act)
`define CTRL_CONNECT 0
`define CTRL_DISC 1
`define CTRL_SEARCH 2
`define CTRL_TEST_ON 3
`define CTRL_TEST_OFF 4
`define CTRL_PSAVE 5
`define CTRL_PKT_END 6
`define CTRL_PARAM_CLR 7
// User settings
`define USER_SLEEP_EN 0
`define USER_TMO_EN 1
`define USER_DEFAULT 2'h3
// Test-mode command bytes
`define TCMD_ACT 8'h32
`define TCMD_MODE 8'h35
`define TCMD_PINS 8'h39
`define TLVL_LO 8'h30
`define TLVL_HI 8'h31
`define RESP_ZERO 8'h00
`endif

// ### core/radio_ctrl_pkg.sv
package radio_ctrl_pkg;
   typedef enum logic [2:0] {ST_BOOT, ST_SEARCH, ST_CONN, ST_STANDBY, ST_PSAVE, ST_TEST}
      link_state_t;
   typedef enum logic {ROLE_PERIPH, ROLE_CENTRAL} role_t;
endpackage : radio_ctrl_pkg

// ### core/radio_host_ctrl.sv
`timescale 1ns/10ps
`include "radio_ctrl_consts.svh"
// Summary of operation
// - Serial port is 38400 baud, eight data bits, no parity, one stop bit.
// - RTS/CTS flow control is on normally and off in test mode.
// - Payload packets are limited to 20 bytes in both directions.
// - On connection the link-state and mode indicators go high.
// - Init input low at startup restores all user settings to defaults.
// - While sleeping, up to 128 bytes are held; excess is dropped silently.
// - Data or events for a sleeping host are held until it is active.
// - Pending data for a sleeping host raises the wake-up request output.
// - Once the host is active the held data goes out on the serial port.
// - The wake-up buffer is 128 bytes; overflow is dropped with no event.
// - Test mode two-byte pin command drives one output and answers 00 00.
// - Test command 39 39 answers input pin levels then 00 00.
// - Sleep is allowed while searching or connected; serial port unused then.
// - Serial data arising during sleep raises the wake-up request output.
// - Disconnect input low over 300 ms after disconnect restarts as central.
// - Transfers are unacknowledged; delivery to the peer is not guaranteed.
// - Role-select sampled at startup: low peripheral, high central.
// - Searching ends after 60 seconds without a connection.
module radio_host_ctrl #(
   parameter int MS_CYC = `MS_CYC,
   parameter int SEARCH_MS = `SEARCH_MS,
   parameter int RESUME_MS = `RESUME_MS,
   parameter int BIT_CYC = `BIT_CYC,
   parameter int DEPTH = `WAKE_DEPTH,
   parameter int PKT_MAX = `PKT_MAX
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic uart_rxd_i,
   output logic uart_txd_o,
   input wire logic uart_cts_n_i,
   output logic uart_rts_n_o,
   input wire logic init_sleep_req_in,
   input wire logic param_change_req_in,
   input wire logic disconnect_resume_in,
   input wire logic role_select_in,
   output logic active_sleep_ind_out,
   output logic link_state_ind_out,
   output logic host_wake_req_out,
   output logic mode_ind_out
);
   localparam logic [16:0] MS_M1 = 17'(MS_CYC - 1);
   localparam logic [15:0] SEARCH_LIM = 16'(SEARCH_MS);
   localparam logic [15:0] RESUME_LIM = 16'(RESUME_MS);
   localparam logic [7:0] DEPTH_L = 8'(DEPTH);
   localparam logic [4:0] PKT_L = 5'(PKT_MAX);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a[7:2] == off[7:2]);
   endfunction : hit

   // Pin command first byte: {valid, output index}
   function automatic logic [2:0] pin_sel(input logic [7:0] b);
      pin_sel = (b >= `TCMD_ACT && b <= `TCMD_MODE) ? {1'b1, 2'(b - `TCMD_ACT)} : 3'h0;
   endfunction : pin_sel

   radio_ctrl_pkg::link_state_t state_ff;
   radio_ctrl_pkg::role_t role_ff;
   logic ack_ff, tick_ff, sleep_ff, lock_ff, param_ff, dc_prev_ff, pc_prev_ff;
   logic [16:0] ms_cnt_ff;
   logic [15:0] search_ms_ff, resume_ms_ff;
   logic [1:0] user_ff;
   logic [7:0] wmem [DEPTH];
   logic [6:0] wr_ptr_ff, rd_ptr_ff;
   logic [7:0] wcnt_ff;
   logic [4:0] pkt_tx_ff, pkt_cnt_ff, pkt_rd_ff;
   logic [7:0] pmem [PKT_MAX];
   logic have_first_ff;
   logic [7:0] first_ff;
   logic [1:0] resp_len_ff;
   logic [3:0] resp_stat_ff, tst_pin_ff;
   logic [7:0] rx_data;
   logic rx_valid, tx_ready, tx_valid, tx_fire;
   logic [7:0] tx_data;

   wire testm = (state_ff == radio_ctrl_pkg::ST_TEST);
   wire normal = !testm && state_ff != radio_ctrl_pkg::ST_BOOT;
   wire host_asleep = role_select_in;
   wire wb_req = cyc_i && stb_i && !ack_ff;
   // Writes land at the edge the master samples ack, while it still holds the request
   wire wr = cyc_i && stb_i && ack_ff && we_i && sel_i[0];
   wire [7:0] cmd = (wr && hit(adr_i, `REG_CTRL)) ? dat_i[7:0] : 8'h00;
   wire push_req = wr && hit(adr_i, `REG_RADIO_TX) && normal;
   wire push = push_req && wcnt_ff < DEPTH_L && pkt_tx_ff < PKT_L;
   wire rx_avail = pkt_rd_ff != pkt_cnt_ff;
   wire pop_rx = wb_req && !we_i && hit(adr_i, `REG_RADIO_RX) && rx_avail;
   wire rx_wr = rx_valid && normal && !sleep_ff && pkt_cnt_ff < PKT_L;
   wire drain = normal && wcnt_ff != 8'h00 && !host_asleep && !sleep_ff && !uart_cts_n_i;
   wire pop_w = tx_fire && normal;
   wire t_exec = rx_valid && testm && have_first_ff;
   wire [2:0] psel = pin_sel(first_ff);
   wire lvl_ok = rx_data == `TLVL_LO || rx_data == `TLVL_HI;

   assign ack_o = ack_ff;
   assign tx_valid = testm ? (resp_len_ff != 2'h0) : drain;
   assign tx_data = testm ? ((resp_len_ff == 2'h3) ? {4'h0, resp_stat_ff} : `RESP_ZERO)
                          : wmem[rd_ptr_ff];
   assign tx_fire = tx_valid && tx_ready;

   uart_link #(.BIT_CYC(BIT_CYC)) u_uart (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tx_data_i(tx_data),
      .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready),
      .txd_o(uart_txd_o),
      .rxd_i(uart_rxd_i),
      .rx_data_o(rx_data),
      .rx_valid_o(rx_valid)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave and millisecond tick
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         dat_o <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= wb_req;
         dat_o <= 32'h0000_0000;
         if (wb_req && !we_i)
         begin
            if (hit(adr_i, `REG_STATUS))
               dat_o <= {11'h000, pkt_cnt_ff, wcnt_ff, param_ff, lock_ff, host_asleep,
                         sleep_ff, role_ff, state_ff};
            else if (hit(adr_i, `REG_RADIO_RX))
               dat_o <= {23'h00_0000, rx_avail, pmem[pkt_rd_ff]};
            else if (hit(adr_i, `REG_USER))
               dat_o <= {30'h0000_0000, user_ff};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || ms_cnt_ff == MS_M1)
         ms_cnt_ff <= 17'h0_0000;
      else
         ms_cnt_ff <= ms_cnt_ff + 17'h0_0001;
      tick_ff <= !rst_i && ms_cnt_ff == MS_M1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link state machine
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= radio_ctrl_pkg::ST_BOOT;
         role_ff <= radio_ctrl_pkg::ROLE_PERIPH;
         lock_ff <= 1'b0;
      end
      else
      begin
         case (state_ff)
            radio_ctrl_pkg::ST_BOOT:
            begin
               role_ff <= role_select_in ? radio_ctrl_pkg::ROLE_CENTRAL
                                         : radio_ctrl_pkg::ROLE_PERIPH;
               lock_ff <= !init_sleep_req_in;
               state_ff <= init_sleep_req_in ? radio_ctrl_pkg::ST_SEARCH
                                             : radio_ctrl_pkg::ST_STANDBY;
            end
            radio_ctrl_pkg::ST_SEARCH:
               if (cmd[`CTRL_CONNECT])
                  state_ff <= radio_ctrl_pkg::ST_CONN;
               else if (cmd[`CTRL_DISC] || (search_ms_ff >= SEARCH_LIM && user_ff[`USER_TMO_EN]))
                  state_ff <= radio_ctrl_pkg::ST_STANDBY;
               else if (cmd[`CTRL_PSAVE])
                  state_ff <= radio_ctrl_pkg::ST_PSAVE;
               else if (cmd[`CTRL_TEST_ON])
                  state_ff <= radio_ctrl_pkg::ST_TEST;
            radio_ctrl_pkg::ST_CONN:
               if (cmd[`CTRL_DISC] || (dc_prev_ff && !disconnect_resume_in))
                  state_ff <= radio_ctrl_pkg::ST_STANDBY;
            radio_ctrl_pkg::ST_STANDBY:
               if (lock_ff)
                  state_ff <= radio_ctrl_pkg::ST_STANDBY;
               else if (resume_ms_ff > RESUME_LIM && !disconnect_resume_in)
               begin
                  state_ff <= radio_ctrl_pkg::ST_SEARCH;
                  role_ff <= radio_ctrl_pkg::ROLE_CENTRAL;
               end
               else if (cmd[`CTRL_SEARCH])
                  state_ff <= radio_ctrl_pkg::ST_SEARCH;
               else if (cmd[`CTRL_PSAVE])
                  state_ff <= radio_ctrl_pkg::ST_PSAVE;
               else if (cmd[`CTRL_TEST_ON])
                  state_ff <= radio_ctrl_pkg::ST_TEST;
            radio_ctrl_pkg::ST_PSAVE:
               if (!role_select_in)
               begin
                  state_ff <= radio_ctrl_pkg::ST_SEARCH;
                  role_ff <= radio_ctrl_pkg::ROLE_PERIPH;
               end
               else if (!disconnect_resume_in)
               begin
                  state_ff <= radio_ctrl_pkg::ST_SEARCH;
                  role_ff <= radio_ctrl_pkg::ROLE_CENTRAL;
               end
            radio_ctrl_pkg::ST_TEST:
               if (cmd[`CTRL_TEST_OFF])
                  state_ff <= radio_ctrl_pkg::ST_STANDBY;
            default:
               state_ff <= radio_ctrl_pkg::ST_BOOT;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || state_ff != radio_ctrl_pkg::ST_SEARCH)
         search_ms_ff <= 16'h0000;
      else if (tick_ff && search_ms_ff != 16'hFFFF)
         search_ms_ff <= search_ms_ff + 16'h0001;
      if (rst_i || state_ff != radio_ctrl_pkg::ST_STANDBY || disconnect_resume_in)
         resume_ms_ff <= 16'h0000;
      else if (tick_ff && resume_ms_ff != 16'hFFFF)
         resume_ms_ff <= resume_ms_ff + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // User settings, sleep and parameter-change request
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         user_ff <= `USER_DEFAULT;
      else if (state_ff == radio_ctrl_pkg::ST_BOOT && !init_sleep_req_in)
         user_ff <= `USER_DEFAULT;
      else if (wr && hit(adr_i, `REG_USER))
         user_ff <= dat_i[1:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sleep_ff <= 1'b0;
         param_ff <= 1'b0;
         dc_prev_ff <= 1'b1;
         pc_prev_ff <= 1'b1;
      end
      else
      begin
         sleep_ff <= user_ff[`USER_SLEEP_EN] && !init_sleep_req_in
                     && (state_ff == radio_ctrl_pkg::ST_SEARCH
                         || state_ff == radio_ctrl_pkg::ST_CONN);
         dc_prev_ff <= disconnect_resume_in;
         pc_prev_ff <= param_change_req_in;
         if (state_ff == radio_ctrl_pkg::ST_CONN && pc_prev_ff && !param_change_req_in)
            param_ff <= 1'b1;
         else if (cmd[`CTRL_PARAM_CLR])
            param_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake-up buffer toward the host
   always_ff @(posedge clk_i)
   begin
      if (push)
         wmem[wr_ptr_ff] <= dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_ptr_ff <= 7'h00;
         rd_ptr_ff <= 7'h00;
         wcnt_ff <= 8'h00;
         pkt_tx_ff <= 5'h00;
      end
      else
      begin
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 7'h01;
         if (pop_w)
            rd_ptr_ff <= rd_ptr_ff + 7'h01;
         if (push && !pop_w)
            wcnt_ff <= wcnt_ff + 8'h01;
         else if (pop_w && !push)
            wcnt_ff <= wcnt_ff - 8'h01;
         if (cmd[`CTRL_PKT_END])
            pkt_tx_ff <= 5'h00;
         else if (push_req && pkt_tx_ff < PKT_L)
            pkt_tx_ff <= pkt_tx_ff + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Packet from the host toward the radio
   always_ff @(posedge clk_i)
   begin
      if (rx_wr)
         pmem[pkt_cnt_ff] <= rx_data;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pkt_cnt_ff <= 5'h00;
         pkt_rd_ff <= 5'h00;
      end
      else if (pop_rx && !rx_wr && pkt_rd_ff + 5'h01 == pkt_cnt_ff)
      begin
         pkt_cnt_ff <= 5'h00;
         pkt_rd_ff <= 5'h00;
      end
      else
      begin
         if (rx_wr)
            pkt_cnt_ff <= pkt_cnt_ff + 5'h01;
         if (pop_rx)
            pkt_rd_ff <= pkt_rd_ff + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Test-mode pin command interpreter
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !testm)
      begin
         have_first_ff <= 1'b0;
         first_ff <= 8'h00;
         resp_len_ff <= 2'h0;
         resp_stat_ff <= 4'h0;
         tst_pin_ff <= 4'h0;
      end
      else if (rx_valid)
      begin
         have_first_ff <= !have_first_ff;
         if (!have_first_ff)
            first_ff <= rx_data;
         else if (psel[2] && lvl_ok)
         begin
            tst_pin_ff[psel[1:0]] <= (rx_data == `TLVL_HI);
            resp_len_ff <= 2'h2;
         end
         else if (first_ff == `TCMD_PINS && rx_data == `TCMD_PINS)
         begin
            resp_stat_ff <= {role_select_in, disconnect_resume_in,
                             param_change_req_in, init_sleep_req_in};
            resp_len_ff <= 2'h3;
         end
         else if (tx_fire)
            resp_len_ff <= resp_len_ff - 2'h1;
      end
      else if (tx_fire)
         resp_len_ff <= resp_len_ff - 2'h1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pins
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         active_sleep_ind_out <= 1'b0;
         link_state_ind_out <= 1'b0;
         host_wake_req_out <= 1'b0;
         mode_ind_out <= 1'b0;
         uart_rts_n_o <= 1'b1;
      end
      else if (testm)
      begin
         {mode_ind_out, host_wake_req_out, link_state_ind_out, active_sleep_ind_out}
            <= tst_pin_ff;
         uart_rts_n_o <= 1'b0;
      end
      else
      begin
         active_sleep_ind_out <= normal && !sleep_ff;
         link_state_ind_out <= state_ff == radio_ctrl_pkg::ST_CONN;
         mode_ind_out <= state_ff == radio_ctrl_pkg::ST_CONN;
         host_wake_req_out <= wcnt_ff != 8'h00 && (host_asleep || sleep_ff);
         uart_rts_n_o <= !normal || sleep_ff || pkt_cnt_ff >= PKT_L;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_conn_ind;
      state_ff == radio_ctrl_pkg::ST_CONN |=> link_state_ind_out && mode_ind_out;
   endproperty
   a_conn_ind: assert property (p_conn_ind) else $error("indicators low while connected");
   property p_standby_ind;
      state_ff == radio_ctrl_pkg::ST_STANDBY [*2] |=> !link_state_ind_out && !mode_ind_out;
   endproperty
   a_standby_ind: assert property (p_standby_ind) else $error("indicators high in standby");
   property p_full_drop;
      wcnt_ff == DEPTH_L && push_req && !pop_w |=> wcnt_ff == DEPTH_L && $stable(wr_ptr_ff);
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full buffer accepted data");
   property p_hold;
      host_asleep |-> !pop_w;
   endproperty
   a_hold: assert property (p_hold) else $error("data sent to sleeping host");
   property p_wake;
      normal && wcnt_ff != 8'h00 && host_asleep ##1 !testm |-> host_wake_req_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake request missing");
   property p_pkt_max;
      pkt_cnt_ff <= PKT_L && pkt_tx_ff <= PKT_L;
   endproperty
   a_pkt_max: assert property (p_pkt_max) else $error("packet over limit");
   property p_flow;
      testm ##1 testm |-> !uart_rts_n_o;
   endproperty
   a_flow: assert property (p_flow) else $error("flow control active in test mode");
   property p_resume;
      state_ff == radio_ctrl_pkg::ST_STANDBY && !lock_ff && resume_ms_ff > RESUME_LIM
      && !disconnect_resume_in |=> state_ff == radio_ctrl_pkg::ST_SEARCH
      && role_ff == radio_ctrl_pkg::ROLE_CENTRAL;
   endproperty
   a_resume: assert property (p_resume) else $error("no central restart");
   property p_boot_role;
      state_ff == radio_ctrl_pkg::ST_BOOT |=> role_ff == $past(role_select_in);
   endproperty
   a_boot_role: assert property (p_boot_role) else $error("role not sampled");
   property p_pin_resp;
      t_exec && psel[2] && lvl_ok |=> resp_len_ff == 2'h2;
   endproperty
   a_pin_resp: assert property (p_pin_resp) else $error("pin command not answered");

   c_connect: cover property (state_ff == radio_ctrl_pkg::ST_SEARCH ##1
                              state_ff == radio_ctrl_pkg::ST_CONN);
   c_full: cover property (wcnt_ff == DEPTH_L && push_req);
   c_status_cmd: cover property (t_exec && first_ff == `TCMD_PINS);
endmodule : radio_host_ctrl

// ### core/uart_link.sv
`timescale 1ns/10ps
`include "radio_ctrl_consts.svh"
module uart_link #(
   parameter int BIT_CYC = `BIT_CYC
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic txd_o,
   input wire logic rxd_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o
);
   localparam logic [11:0] BIT_M1 = 12'(BIT_CYC - 1);
   localparam logic [11:0] HALF_M1 = 12'(BIT_CYC / 2 - 1);

   logic [9:0] tx_sh_ff;
   logic [3:0] tx_bits_ff;
   logic [11:0] tx_cnt_ff;
   logic rx_busy_ff;
   logic [3:0] rx_bits_ff;
   logic [11:0] rx_cnt_ff;
   logic [8:0] rx_sh_ff;

   assign tx_ready_o = (tx_bits_ff == 4'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // 8N1 transmitter, line idles high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tx_sh_ff <= 10'h3FF;
         tx_bits_ff <= 4'h0;
         tx_cnt_ff <= 12'h000;
      end
      else if (tx_bits_ff == 4'h0)
      begin
         if (tx_valid_i)
         begin
            tx_sh_ff <= {1'b1, tx_data_i, 1'b0};
            tx_bits_ff <= 4'hA;
            tx_cnt_ff <= BIT_M1;
         end
      end
      else if (tx_cnt_ff == 12'h000)
      begin
         tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
         tx_bits_ff <= tx_bits_ff - 4'h1;
         tx_cnt_ff <= BIT_M1;
      end
      else
         tx_cnt_ff <= tx_cnt_ff - 12'h001;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         txd_o <= 1'b1;
      else
         txd_o <= (tx_bits_ff == 4'h0) ? 1'b1 : tx_sh_ff[0];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receiver: samples mid-bit, drops frames with a bad stop bit
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_busy_ff <= 1'b0;
         rx_bits_ff <= 4'h0;
         rx_cnt_ff <= 12'h000;
         rx_sh_ff <= 9'h000;
         rx_data_o <= 8'h00;
         rx_valid_o <= 1'b0;
      end
      else
      begin
         rx_valid_o <= 1'b0;
         if (!rx_busy_ff)
         begin
            if (!rxd_i)
            begin
               rx_busy_ff <= 1'b1;
               rx_bits_ff <= 4'h0;
               rx_cnt_ff <= HALF_M1;
            end
         end
         else if (rx_cnt_ff != 12'h000)
            rx_cnt_ff <= rx_cnt_ff - 12'h001;
         else if (rx_bits_ff == 4'h0 && rxd_i)
            rx_busy_ff <= 1'b0;
         else if (rx_bits_ff == 4'h9)
         begin
            rx_busy_ff <= 1'b0;
            rx_data_o <= rx_sh_ff[8:1];
            rx_valid_o <= rxd_i;
         end
         else
         begin
            rx_sh_ff <= {rxd_i, rx_sh_ff[8:1]};
            rx_bits_ff <= rx_bits_ff + 4'h1;
            rx_cnt_ff <= BIT_M1;
         end
      end
   end
endmodule : uart_link
